// ### rtl/cpm_pkg.sv
// package: register map, field layout and event codes of the coherency perf monitor
package cpm_pkg;
   // ==========================================================
   // register map (byte addresses, one aligned word each)
   localparam logic [5:0] CPM_ADDR_CTRL = 6'h00; // perf_monitor_control
   localparam logic [5:0] CPM_ADDR_SEL_LO = 6'h04; // event_select_low, counters 0-3
   localparam logic [5:0] CPM_ADDR_SEL_HI = 6'h08; // event_select_high, counters 4-7
   localparam logic [5:0] CPM_ADDR_CNT0 = 6'h10; // event_counter_n at 0x10 + 4n
   localparam int CPM_ADDR_LSB = 2; // word index lsb
   localparam int CPM_MAX_CNT = 8; // counters at four cpus
   localparam int CPM_CNT_PER_CPU = 2; // counters per configured cpu
   // ==========================================================
   // control register fields
   localparam int CPM_CTRL_EN = 0; // global enable
   localparam int CPM_CTRL_CLR = 1; // clear-all command
   localparam int CPM_CTRL_IEN_LSB = 8; // counter_irq_enable [15:8]
   localparam int CPM_CTRL_OVF_LSB = 16; // overflow flags [23:16]
   localparam int CPM_IRQ_LSB = 4; // perf_overflow_irq [11:4]
   localparam int CPM_IRQ_W = 12; // width of irq bus
   localparam int CPM_CODE_W = 8; // event code field width
   // ==========================================================
   // event codes
   localparam logic [7:0] CPM_EV_OFF = 8'h00; // counter disabled
   localparam logic [7:0] CPM_EV_MISS0 = 8'h01; // linefill miss cpu0..3
   localparam logic [7:0] CPM_EV_HIT0 = 8'h05; // linefill hit cpu0..3
   localparam logic [7:0] CPM_EV_NPRS0 = 8'h09; // nonpresent answer cpu0..3
   localparam logic [7:0] CPM_EV_MIGR = 8'h0D; // line migration
   localparam logic [7:0] CPM_EV_RBUSY0 = 8'h0E; // master read busy 0..1
   localparam logic [7:0] CPM_EV_WBUSY0 = 8'h10; // master write busy 0..1
   localparam logic [7:0] CPM_EV_XRD = 8'h12; // external read transfer
   localparam logic [7:0] CPM_EV_XWR = 8'h13; // external write transfer
   localparam logic [7:0] CPM_EV_CYCLE = 8'h1F; // every cycle
   localparam logic [1:0] CPM_RESP_OKAY = 2'b00; // axi okay
   localparam logic [1:0] CPM_RESP_SLVERR = 2'b10; // axi slave error
   // raw event strobes from the coherency control unit
   typedef struct packed
   {
      logic [3:0] lf_miss; // linefill missed all, per cpu
      logic [3:0] lf_hit; // linefill hit other cpu, per cpu
      logic [3:0] nonpresent; // expected line absent, per cpu
      logic migrate; // line migration
      logic [1:0] rd_busy; // master read port busy
      logic [1:0] wr_busy; // master write port busy
      logic ext_rd; // external read transfer
      logic ext_wr; // external write transfer
   } cpm_events_t;
endpackage

// ### rtl/cpm_perf_monitor.sv
// module: coherency perf monitor, counters, control and axi4-lite slave
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module cpm_perf_monitor
   import cpm_pkg::*;
#(
   parameter int NUM_CPUS = 4, // configured cpus, 1..4
   parameter int CNT_W = 32 // counter width
)
(
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire cpm_events_t EVENTS,
   output logic [CPM_IRQ_W-1:0] PERF_OVERFLOW_IRQ,
   input wire logic [5:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [5:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   // ==========================================================
   // configuration
   localparam int NCNT = NUM_CPUS * CPM_CNT_PER_CPU; // counters present
   localparam logic [CPM_MAX_CNT-1:0] PRESENT = CPM_MAX_CNT'((1 << NCNT) - 1);
   localparam logic [CNT_W-1:0] CNT_ONES = '1; // wrap point

   logic en_ff; // global enable
   logic [CPM_MAX_CNT-1:0] ien_ff; // interrupt enables
   logic [CPM_MAX_CNT-1:0] ovf_ff; // sticky overflow flags
   logic [CPM_CODE_W-1:0] code_ff [CPM_MAX_CNT]; // event codes
   logic [CNT_W-1:0] cnt_ff [CPM_MAX_CNT]; // counters
   logic [CPM_MAX_CNT-1:0] hit; // selected event seen this cycle
   logic [CPM_MAX_CNT-1:0] wrap; // counter wraps this cycle

   // ==========================================================
   // axi write channel: take aw and w in either order
   logic aw_got_ff; // address held
   logic w_got_ff; // data held
   logic [5:0] awaddr_ff; // latched address
   logic [31:0] wdata_ff; // latched data
   logic [3:0] wstrb_ff; // latched strobes
   logic wr_fire; // both halves present, do the write
   logic bvalid_ff;
   logic [1:0] bresp_ff;

   assign S_AXI_AWREADY = !aw_got_ff && !bvalid_ff;
   assign S_AXI_WREADY = !w_got_ff && !bvalid_ff;
   assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;

   // latch address and data halves
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 6'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= S_AXI_AWADDR;
         end
         else if (wr_fire)
            aw_got_ff <= 1'b0;
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_got_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
         end
         else if (wr_fire)
            w_got_ff <= 1'b0;
      end
   end

   // decode write target
   logic wr_ctrl, wr_sel_lo, wr_sel_hi, wr_map;
   logic [CPM_MAX_CNT-1:0] wr_cnt; // per-counter write hit
   logic [31:0] wmask; // byte enables as bit mask
   always_comb
   begin
      wr_ctrl = wr_fire && (awaddr_ff == CPM_ADDR_CTRL);
      wr_sel_lo = wr_fire && (awaddr_ff == CPM_ADDR_SEL_LO);
      wr_sel_hi = wr_fire && (awaddr_ff == CPM_ADDR_SEL_HI);
      for (int i = 0; i < CPM_MAX_CNT; i++)
         wr_cnt[i] = wr_fire && (awaddr_ff == 6'(CPM_ADDR_CNT0 + 4 * i)) && PRESENT[i];
      wr_map = wr_ctrl || wr_sel_lo || wr_sel_hi || (|wr_cnt);
      for (int b = 0; b < 4; b++)
         wmask[8*b +: 8] = {8{wstrb_ff[b]}};
   end

   // write response; unmapped writes get slverr
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= CPM_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_map ? CPM_RESP_OKAY : CPM_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
         bvalid_ff <= 1'b0;
   end

   // ==========================================================
   // control register
   logic [31:0] wctrl; // strobed control write data
   assign wctrl = wdata_ff & wmask;

   // global enable and interrupt enables
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         en_ff <= 1'b0;
         ien_ff <= 8'h00;
      end
      else if (wr_ctrl)
      begin
         if (wstrb_ff[0])
            en_ff <= wdata_ff[CPM_CTRL_EN];
         if (wstrb_ff[1])
            ien_ff <= wdata_ff[CPM_CTRL_IEN_LSB +: CPM_MAX_CNT] & PRESENT;
      end
   end

   // write-one clear mask; zero bits leave their flag alone
   logic [CPM_MAX_CNT-1:0] ovf_clr;
   assign ovf_clr = wr_ctrl ? wctrl[CPM_CTRL_OVF_LSB +: CPM_MAX_CNT] : 8'h00;

   // sticky flags: a new overflow beats a write-one clear
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
         ovf_ff <= 8'h00;
      else
         ovf_ff <= ((ovf_ff & ~ovf_clr) | wrap) & PRESENT;
   end

   // clear-all command is a pulse, the bit is not stored
   logic clr_all;
   assign clr_all = wr_ctrl && wctrl[CPM_CTRL_CLR];

   // ==========================================================
   // event codes, 8 bits each, counter 0 in the low byte
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         for (int i = 0; i < CPM_MAX_CNT; i++)
            code_ff[i] <= CPM_EV_OFF;
      end
      else
      begin
         for (int i = 0; i < CPM_MAX_CNT; i++)
         begin
            if (PRESENT[i] && ((i < 4 && wr_sel_lo) || (i >= 4 && wr_sel_hi))
                && wstrb_ff[i % 4])
               code_ff[i] <= wdata_ff[8*(i%4) +: CPM_CODE_W];
         end
      end
   end

   // ==========================================================
   // event select per counter
   function automatic logic ev_pick(input logic [CPM_CODE_W-1:0] c, input cpm_events_t e);
      logic r;
      r = 1'b0;
      if (c >= CPM_EV_MISS0 && c < CPM_EV_HIT0)
         r = e.lf_miss[2'(c - CPM_EV_MISS0)];
      else if (c >= CPM_EV_HIT0 && c < CPM_EV_NPRS0)
         r = e.lf_hit[2'(c - CPM_EV_HIT0)];
      else if (c >= CPM_EV_NPRS0 && c < CPM_EV_MIGR)
         r = e.nonpresent[2'(c - CPM_EV_NPRS0)];
      else if (c == CPM_EV_MIGR)
         r = e.migrate;
      else if (c >= CPM_EV_RBUSY0 && c < CPM_EV_WBUSY0)
         r = e.rd_busy[1'(c - CPM_EV_RBUSY0)];
      else if (c >= CPM_EV_WBUSY0 && c < CPM_EV_XRD)
         r = e.wr_busy[1'(c - CPM_EV_WBUSY0)];
      else if (c == CPM_EV_XRD)
         r = e.ext_rd;
      else if (c == CPM_EV_XWR)
         r = e.ext_wr;
      else if (c == CPM_EV_CYCLE)
         r = 1'b1;
      // code 0, 20-30 and above 31 stay idle
      return r;
   endfunction

   // hit and wrap per counter
   always_comb
   begin
      for (int i = 0; i < CPM_MAX_CNT; i++)
      begin
         hit[i] = PRESENT[i] && en_ff && ev_pick(code_ff[i], EVENTS);
         wrap[i] = hit[i] && !clr_all && !wr_cnt[i] && (cnt_ff[i] == CNT_ONES);
      end
   end

   // ==========================================================
   // counters; software write and clear-all take priority over counting
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         for (int i = 0; i < CPM_MAX_CNT; i++)
            cnt_ff[i] <= '0;
      end
      else
      begin
         for (int i = 0; i < CPM_MAX_CNT; i++)
         begin
            if (!PRESENT[i])
               cnt_ff[i] <= '0;
            else if (clr_all)
               cnt_ff[i] <= '0;
            else if (wr_cnt[i])
               cnt_ff[i] <= (cnt_ff[i] & ~CNT_W'(wmask)) | (CNT_W'(wdata_ff) & CNT_W'(wmask));
            else if (hit[i])
               cnt_ff[i] <= cnt_ff[i] + 1'b1;
         end
      end
   end

   // ==========================================================
   // interrupt outputs, registered
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
         PERF_OVERFLOW_IRQ <= 12'h000;
      else
         PERF_OVERFLOW_IRQ <= {ovf_ff & ien_ff, 4'h0};
   end

   // ==========================================================
   // axi read channel, one read at a time, answer one cycle after ar
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   assign S_AXI_ARREADY = !rvalid_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;

   // read mux
   logic [31:0] rmux;
   logic rmap;
   always_comb
   begin
      rmux = 32'h0000_0000;
      rmap = 1'b1;
      if (S_AXI_ARADDR == CPM_ADDR_CTRL)
      begin
         rmux[CPM_CTRL_EN] = en_ff;
         rmux[CPM_CTRL_IEN_LSB +: CPM_MAX_CNT] = ien_ff;
         rmux[CPM_CTRL_OVF_LSB +: CPM_MAX_CNT] = ovf_ff;
      end
      else if (S_AXI_ARADDR == CPM_ADDR_SEL_LO)
         rmux = {code_ff[3], code_ff[2], code_ff[1], code_ff[0]};
      else if (S_AXI_ARADDR == CPM_ADDR_SEL_HI)
         rmux = {code_ff[7], code_ff[6], code_ff[5], code_ff[4]};
      else
      begin
         rmap = 1'b0;
         for (int i = 0; i < CPM_MAX_CNT; i++)
            if (PRESENT[i] && S_AXI_ARADDR == 6'(CPM_ADDR_CNT0 + 4 * i))
            begin
               rmux = 32'(cnt_ff[i]);
               rmap = 1'b1;
            end
      end
   end

   // read data register
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= CPM_RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rmux;
         rresp_ff <= rmap ? CPM_RESP_OKAY : CPM_RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
         rvalid_ff <= 1'b0;
   end

   // ==========================================================
   // assertions
   a_wrap_sets_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      wrap[0] |=> ovf_ff[0]) else $error("overflow flag not set on wrap");
   a_flag_clear_one: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (wr_ctrl && wctrl[CPM_CTRL_OVF_LSB] && !wrap[0]) |=> !ovf_ff[0])
      else $error("flag not cleared by one");
   a_absent_ien_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (ien_ff & ~PRESENT) == 8'h00) else $error("absent enable reads one");
   a_clear_all_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      clr_all |=> cnt_ff[0] == '0) else $error("clear all missed");
   a_disabled_holds: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (!en_ff && !clr_all && !wr_cnt[0]) |=> $stable(cnt_ff[0]))
      else $error("counter moved while disabled");
   a_irq_follows: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (ovf_ff[0] && ien_ff[0]) |=> PERF_OVERFLOW_IRQ[CPM_IRQ_LSB])
      else $error("irq bit not raised");
   a_cycle_count: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (en_ff && code_ff[0] == CPM_EV_CYCLE && !clr_all && !wr_cnt[0])
      |=> cnt_ff[0] == $past(cnt_ff[0]) + 1'b1) else $error("cycle count missed");
   a_count_step: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (hit[0] && !clr_all && !wr_cnt[0]) |=> cnt_ff[0] == $past(cnt_ff[0]) + 1'b1)
      else $error("counter missed an event");
   a_irq_drops: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      !(ovf_ff[0] && ien_ff[0]) |=> !PERF_OVERFLOW_IRQ[CPM_IRQ_LSB])
      else $error("irq bit without flag and enable");
   a_undef_code_idle: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (code_ff[0] > CPM_EV_XWR && code_ff[0] < CPM_EV_CYCLE) |-> !hit[0])
      else $error("undefined code counted");
   c_wrap: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) wrap[0]);
   c_irq: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) |PERF_OVERFLOW_IRQ);
   c_clear: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) clr_all);

   // cover points for cycle counting and a write-one clear of a set flag
   c_cycle_code: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
      en_ff && code_ff[0] == CPM_EV_CYCLE);
   c_flag_clear: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
      ovf_clr[0] && ovf_ff[0]);
endmodule

// ### dv/cpm_perf_monitor_tb.sv
// testbench: register, counting, overflow and interrupt checks of the perf monitor
`timescale 1ns/1ps
module cpm_perf_monitor_tb;
   import cpm_pkg::*;
   // ==========================================================
   // setup and signals
   localparam int NC = 3; // three cpus, so counters 6 and 7 are absent
   localparam int CW = 4; // short counters so a wrap comes quickly
   typedef struct packed
   {
      logic [31:0] d; // expected read word
      logic [1:0] r; // expected response
   } cpm_exp_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   cpm_events_t ev = '0; // event strobes driven by the bench
   logic [CPM_IRQ_W-1:0] irq;
   logic [5:0] awaddr = '0;
   logic [5:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hF; // byte strobes, full word unless a test narrows them
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   cpm_exp_t rq[$]; // notes of expected reads
   logic [1:0] bq[$]; // notes of expected write responses
   int n_errors = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'h0000_6a35;
   logic [31:0] v;

   cpm_perf_monitor #(.NUM_CPUS(NC), .CNT_W(CW)) i_cpm_perf_monitor
   (
      .CLK_SYS(clk), .SYS_RST(rst), .EVENTS(ev), .PERF_OVERFLOW_IRQ(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
   );

   // 200 mhz clock
   always #2.5 clk = ~clk;

   // ==========================================================
   // helpers
   // xorshift source, fixed start
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // word compare, counted
   task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // response code compare, counted
   task automatic cmp_resp(string what, logic [1:0] exp, logic [1:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // event strobe that a given code should count; none for undefined codes
   function automatic cpm_events_t evsel(int c);
      cpm_events_t e;
      e = '0;
      if (c >= 1 && c <= 4) e.lf_miss[c-1] = 1'b1;
      else if (c >= 5 && c <= 8) e.lf_hit[c-5] = 1'b1;
      else if (c >= 9 && c <= 12) e.nonpresent[c-9] = 1'b1;
      else if (c == 13) e.migrate = 1'b1;
      else if (c == 14 || c == 15) e.rd_busy[c-14] = 1'b1;
      else if (c == 16 || c == 17) e.wr_busy[c-16] = 1'b1;
      else if (c == 18) e.ext_rd = 1'b1;
      else if (c == 19) e.ext_wr = 1'b1;
      return e;
   endfunction

   // axi4-lite write; ready is looked at on the falling edge, where it is settled
   task automatic wr(logic [5:0] a, logic [31:0] d, logic [1:0] r);
      logic ta, tw, gb;
      bq.push_back(r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      gb = 1'b0;
      while (!(ta && tw))
      begin
         @(negedge clk);
         ta = ta || (awready && awvalid);
         tw = tw || (wready && wvalid);
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      while (!gb)
      begin
         @(negedge clk);
         gb = bvalid;
         @(posedge clk);
      end
      bready <= 1'b0;
   endtask

   // axi4-lite read, expectation noted first
   task automatic rd(logic [5:0] a, logic [31:0] d, logic [1:0] r);
      logic t, g;
      rq.push_back('{d, r});
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      t = 1'b0;
      g = 1'b0;
      while (!t)
      begin
         @(negedge clk);
         t = arready;
         @(posedge clk);
      end
      arvalid <= 1'b0;
      while (!g)
      begin
         @(negedge clk);
         g = rvalid;
         @(posedge clk);
      end
      rready <= 1'b0;
   endtask

   // ==========================================================
   // result watcher: takes the oldest note when an answer stands
   always @(negedge clk)
   begin
      cpm_exp_t e;
      if (rvalid && rready)
      begin
         e = rq.pop_front();
         cmp("read data", e.d, rdata);
         cmp_resp("read resp", e.r, rresp);
      end
      if (bvalid && bready)
         cmp_resp("write resp", bq.pop_front(), bresp);
   end

   // verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // watchdog, well beyond the fewer than a thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      results();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(CPM_ADDR_CTRL, 32'h0000_0000, CPM_RESP_OKAY);
      rd(CPM_ADDR_SEL_LO, 32'h0000_0000, CPM_RESP_OKAY);
      rd(CPM_ADDR_CNT0, 32'h0000_0000, CPM_RESP_OKAY);
      rd(6'h0C, 32'h0000_0000, CPM_RESP_SLVERR);
      wr(CPM_ADDR_CNT0 + 6'h18, 32'h0000_0005, CPM_RESP_SLVERR);
      rd(CPM_ADDR_CNT0 + 6'h18, 32'h0000_0000, CPM_RESP_SLVERR);
      rd(CPM_ADDR_CNT0 + 6'h14, 32'h0000_0000, CPM_RESP_OKAY);
      // enables of absent counters read back as zero
      wr(CPM_ADDR_CTRL, 32'h0000_FF00, CPM_RESP_OKAY);
      rd(CPM_ADDR_CTRL, 32'h0000_3F00, CPM_RESP_OKAY);
      // random select codes and counter values
      v = xs();
      wr(CPM_ADDR_SEL_HI, v, CPM_RESP_OKAY);
      rd(CPM_ADDR_SEL_HI, {16'h0000, v[15:0]}, CPM_RESP_OKAY);
      // one byte strobe touches only the code of counter 5
      wstrb <= 4'h2;
      wr(CPM_ADDR_SEL_HI, 32'hFFFF_FFFF, CPM_RESP_OKAY);
      wstrb <= 4'hF;
      rd(CPM_ADDR_SEL_HI, {16'h0000, 8'hFF, v[7:0]}, CPM_RESP_OKAY);
      v = xs();
      wr(CPM_ADDR_CNT0 + 6'h04, v, CPM_RESP_OKAY);
      rd(CPM_ADDR_CNT0 + 6'h04, {28'h000_0000, v[3:0]}, CPM_RESP_OKAY);
      wr(CPM_ADDR_SEL_HI, 32'h0000_0000, CPM_RESP_OKAY);
      wr(CPM_ADDR_CTRL, 32'h0000_0001, CPM_RESP_OKAY);
      // codes 0 to 30: three target cycles count, two of all other events do not
      for (int c = 0; c < 31; c++)
      begin
         wr(CPM_ADDR_SEL_LO, {24'h00_0000, c[7:0]}, CPM_RESP_OKAY);
         wr(CPM_ADDR_CNT0, 32'h0000_0000, CPM_RESP_OKAY);
         @(posedge clk);
         ev <= evsel(c);
         repeat (3) @(posedge clk);
         ev <= ~evsel(c);
         repeat (2) @(posedge clk);
         ev <= '0;
         wr(CPM_ADDR_SEL_LO, 32'h0000_0000, CPM_RESP_OKAY);
         rd(CPM_ADDR_CNT0, (c >= 1 && c <= 19) ? 32'h3 : 32'h0, CPM_RESP_OKAY);
      end
      // cycle code wraps the short counter; flag and interrupt follow
      wr(CPM_ADDR_CTRL, 32'h0000_0101, CPM_RESP_OKAY);
      wr(CPM_ADDR_SEL_LO, 32'h0000_001F, CPM_RESP_OKAY);
      repeat (20) @(posedge clk);
      @(negedge clk);
      cmp("irq", 32'h0000_0010, {20'h0_0000, irq});
      rd(CPM_ADDR_CTRL, 32'h0001_0101, CPM_RESP_OKAY);
      // interrupt enable off gates the interrupt, a zero keeps the flag
      wr(CPM_ADDR_CTRL, 32'h0000_0001, CPM_RESP_OKAY);
      repeat (2) @(negedge clk);
      cmp("irq", 32'h0000_0000, {20'h0_0000, irq});
      rd(CPM_ADDR_CTRL, 32'h0001_0001, CPM_RESP_OKAY);
      // stop counting first so no fresh wrap races the clear
      wr(CPM_ADDR_CTRL, 32'h0000_0000, CPM_RESP_OKAY);
      wr(CPM_ADDR_CTRL, 32'h0001_0000, CPM_RESP_OKAY);
      rd(CPM_ADDR_CTRL, 32'h0000_0000, CPM_RESP_OKAY);
      wr(CPM_ADDR_CNT0, 32'h0000_0005, CPM_RESP_OKAY);
      repeat (4) @(posedge clk);
      rd(CPM_ADDR_CNT0, 32'h0000_0005, CPM_RESP_OKAY);
      // clear-all empties counters 0 and 1, bit reads back zero
      wr(CPM_ADDR_CNT0 + 6'h04, 32'h0000_0007, CPM_RESP_OKAY);
      wr(CPM_ADDR_CTRL, 32'h0000_0002, CPM_RESP_OKAY);
      rd(CPM_ADDR_CNT0, 32'h0000_0000, CPM_RESP_OKAY);
      rd(CPM_ADDR_CNT0 + 6'h04, 32'h0000_0000, CPM_RESP_OKAY);
      rd(CPM_ADDR_CTRL, 32'h0000_0000, CPM_RESP_OKAY);
      results();
   end
endmodule
